// ### logic/playback_pkg.sv
// Shared constants for the waveform playback trigger controller
`default_nettype none
package playback_pkg;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int unsigned CLK_FREQ_HZ   = 10_000_000;
   localparam int unsigned NS_PER_S      = 1_000_000_000;
   localparam int unsigned CLK_PERIOD_NS = NS_PER_S / CLK_FREQ_HZ;

   // ----------------------------------------
   // Widths
   // ----------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int IDX_W  = 16;
   localparam int SEG_W  = 8;
   localparam int REP_W  = 16;
   localparam int DLY_W  = 24;
   localparam int DIV_W  = 16;

   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_REPEAT = 8'h04;
   localparam logic [7:0] OFS_DELAY  = 8'h08;
   localparam logic [7:0] OFS_SEGIDX = 8'h0C;
   localparam logic [7:0] OFS_CLKDIV = 8'h10;
   localparam logic [7:0] OFS_EXEC   = 8'h14;
   localparam logic [7:0] OFS_STATUS = 8'h18;
   localparam logic [7:0] OFS_LENGTH = 8'h1C;
   localparam logic [7:0] OFS_NSEG   = 8'h20;

   // ----------------------------------------
   // Control field positions
   // ----------------------------------------
   localparam int CTRL_W       = 15;
   localparam int F_ENABLE     = 0;
   localparam int F_SOURCE     = 1;
   localparam int F_MODE_LO    = 2;
   localparam int F_CSUB_LO    = 4;
   localparam int F_SPOL_LO    = 6;
   localparam int F_GATE_HIGH  = 8;
   localparam int F_SLOPE_FALL = 9;
   localparam int F_DLY_EN     = 10;
   localparam int F_DLY_TIME   = 11;
   localparam int F_IS_SEQ     = 12;
   localparam int F_SEQ_LO     = 13;

   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [CTRL_W-1:0] RST_CTRL   = 15'h0100;
   localparam logic [REP_W-1:0]  RST_REPEAT = 16'h0001;
   localparam logic [DLY_W-1:0]  RST_DELAY  = 24'h000000;
   localparam logic [SEG_W-1:0]  RST_SEGIDX = 8'h00;
   localparam logic [DIV_W-1:0]  RST_CLKDIV = 16'h0000;
   localparam logic [IDX_W-1:0]  RST_LENGTH = 16'h0100;
   localparam logic [SEG_W-1:0]  RST_NSEG   = 8'h01;

   // ----------------------------------------
   // Encodings
   // ----------------------------------------
   localparam logic [1:0] MODE_CONT   = 2'h0;
   localparam logic [1:0] MODE_SINGLE = 2'h1;
   localparam logic [1:0] MODE_GATED  = 2'h2;
   localparam logic [1:0] MODE_REPEAT = 2'h3;
   localparam logic [1:0] CSUB_AUTO   = 2'h0;
   localparam logic [1:0] CSUB_TRIG   = 2'h1;
   localparam logic [1:0] CSUB_RT     = 2'h2;
   localparam logic [1:0] SPOL_IGNORE = 2'h0;
   localparam logic [1:0] SPOL_BUFFER = 2'h1;
   localparam logic [1:0] SPOL_RT     = 2'h2;
   localparam logic [1:0] SEQ_SINGLE  = 2'h0;
   localparam logic [1:0] SEQ_ORDER   = 2'h1;
   localparam logic [1:0] SEQ_FULL    = 2'h2;

   typedef enum logic [1:0] {ST_OFF, ST_WAIT, ST_RUN} play_state_t;
endpackage : playback_pkg
`default_nettype wire

// ### logic/rate_divider.sv
// Sample rate enable divider
`default_nettype none
module rate_divider
   import playback_pkg::*;
(
   input  wire logic             ref_clk,
   input  wire logic             rstn,
   input  wire logic [DIV_W-1:0] div_val,
   output logic                  sample_en
);
   logic [DIV_W-1:0] cnt_q;

   // Divide by div_val+1; zero gives a sample every cycle
   assign sample_en = (cnt_q >= div_val);

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= sample_en ? '0 : cnt_q + 16'h0001;
      end
   end
endmodule : rate_divider
`default_nettype wire

// ### logic/ext_trig_cond.sv
// External trigger edge detect and delay
`default_nettype none
module ext_trig_cond
   import playback_pkg::*;
(
   input  wire logic             ref_clk,
   input  wire logic             rstn,
   input  wire logic             ext_in,
   input  wire logic             slope_fall,
   input  wire logic             dly_en,
   input  wire logic             dly_time,
   input  wire logic [DLY_W-1:0] dly_val,
   input  wire logic             sample_en,
   output logic                  fire,
   output logic                  dly_busy
);
   logic             prev_q;
   logic             busy_q;
   logic             fire_q;
   logic [DLY_W:0]   acc_q;
   logic             edge_hit;
   logic             dly_done;
   logic [DLY_W:0]   acc_step;

   assign edge_hit = slope_fall ? (prev_q & ~ext_in) : (~prev_q & ext_in);
   // Time unit accumulates nanoseconds per clock, sample unit counts samples
   assign acc_step = dly_time ? (DLY_W+1)'(CLK_PERIOD_NS) : {{DLY_W{1'b0}}, sample_en};
   assign dly_done = busy_q & (acc_q >= {1'b0, dly_val});
   assign fire     = fire_q;
   assign dly_busy = busy_q;

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         prev_q <= 1'b0;
         busy_q <= 1'b0;
         fire_q <= 1'b0;
         acc_q  <= '0;
      end else begin
         prev_q <= ext_in;
         fire_q <= (edge_hit & ~dly_en) | dly_done;
         // Edges during a running delay are dropped, one delay at a time
         if (dly_done) begin
            busy_q <= 1'b0;
         end else if (edge_hit & dly_en & ~busy_q) begin
            busy_q <= 1'b1;
            acc_q  <= '0;
         end else if (busy_q) begin
            acc_q  <= acc_q + acc_step;
         end
      end
   end

   a_edge_nodelay: assert property (@(posedge ref_clk) disable iff (!rstn)
      edge_hit && !dly_en |=> fire) else $error("undelayed edge did not fire");
endmodule : ext_trig_cond
`default_nettype wire

// ### logic/arb_playback_trigger_ctrl.sv
// Trigger and playback control for the arbitrary waveform player
`default_nettype none
module arb_playback_trigger_ctrl
   import playback_pkg::*;
(
   input  wire logic              ref_clk,
   input  wire logic              rstn,
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic [DATA_W-1:0] reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [DATA_W-1:0] reg_rdata,
   input  wire logic              ext_trig_in,
   output logic      [SEG_W-1:0]  sample_seg,
   output logic      [IDX_W-1:0]  sample_idx,
   output logic                   sample_valid,
   output logic                   other_mod_off
);
   // ----------------------------------------
   // Registers
   // ----------------------------------------
   logic [CTRL_W-1:0] ctrl_q;
   logic [REP_W-1:0]  repeat_q;
   logic [DLY_W-1:0]  delay_q;
   logic [SEG_W-1:0]  segidx_q;
   logic [DIV_W-1:0]  clkdiv_q;
   logic [IDX_W-1:0]  length_q;
   logic [SEG_W-1:0]  nseg_q;
   logic [DATA_W-1:0] rdata_q;

   wire wr_ctrl   = reg_wr & (reg_addr == OFS_CTRL);
   wire wr_repeat = reg_wr & (reg_addr == OFS_REPEAT);
   wire wr_delay  = reg_wr & (reg_addr == OFS_DELAY);
   wire wr_segidx = reg_wr & (reg_addr == OFS_SEGIDX);
   wire wr_clkdiv = reg_wr & (reg_addr == OFS_CLKDIV);
   wire wr_exec   = reg_wr & (reg_addr == OFS_EXEC);
   wire wr_length = reg_wr & (reg_addr == OFS_LENGTH);
   wire wr_nseg   = reg_wr & (reg_addr == OFS_NSEG);

   wire       enable     = ctrl_q[F_ENABLE];
   wire       src_ext    = ctrl_q[F_SOURCE];
   wire [1:0] mode       = ctrl_q[F_MODE_LO +: 2];
   wire [1:0] csub       = ctrl_q[F_CSUB_LO +: 2];
   wire [1:0] spol       = ctrl_q[F_SPOL_LO +: 2];
   wire       gate_high  = ctrl_q[F_GATE_HIGH];
   wire       is_seq     = ctrl_q[F_IS_SEQ];
   wire [1:0] seq_mode   = ctrl_q[F_SEQ_LO +: 2];

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_q   <= RST_CTRL;
         repeat_q <= RST_REPEAT;
         delay_q  <= RST_DELAY;
         segidx_q <= RST_SEGIDX;
         clkdiv_q <= RST_CLKDIV;
         length_q <= RST_LENGTH;
         nseg_q   <= RST_NSEG;
      end else begin
         if (wr_ctrl)   ctrl_q   <= reg_wdata[CTRL_W-1:0];
         if (wr_repeat) repeat_q <= reg_wdata[REP_W-1:0];
         if (wr_delay)  delay_q  <= reg_wdata[DLY_W-1:0];
         if (wr_segidx) segidx_q <= reg_wdata[SEG_W-1:0];
         if (wr_clkdiv) clkdiv_q <= reg_wdata[DIV_W-1:0];
         if (wr_length) length_q <= reg_wdata[IDX_W-1:0];
         if (wr_nseg)   nseg_q   <= reg_wdata[SEG_W-1:0];
      end
   end

   // ----------------------------------------
   // Sample rate and external trigger
   // ----------------------------------------
   logic sample_en;
   logic ext_fire;
   logic dly_busy;

   rate_divider u_div (
      .ref_clk   (ref_clk),
      .rstn      (rstn),
      .div_val   (clkdiv_q),
      .sample_en (sample_en)
   );

   ext_trig_cond u_ext (
      .ref_clk    (ref_clk),
      .rstn       (rstn),
      .ext_in     (ext_trig_in),
      .slope_fall (ctrl_q[F_SLOPE_FALL]),
      .dly_en     (ctrl_q[F_DLY_EN]),
      .dly_time   (ctrl_q[F_DLY_TIME]),
      .dly_val    (delay_q),
      .sample_en  (sample_en),
      .fire       (ext_fire),
      .dly_busy   (dly_busy)
   );

   wire trig     = src_ext ? ext_fire : wr_exec;
   wire gate_act = ~(ext_trig_in ^ gate_high);

   // ----------------------------------------
   // Sample walk
   // ----------------------------------------
   play_state_t       st_q;
   play_state_t       st_d;
   logic [IDX_W-1:0]  idx_q;
   logic [SEG_W-1:0]  seg_q;
   logic [REP_W-1:0]  rep_q;
   logic [REP_W-1:0]  rep_d;
   logic              pend_q;
   logic              pend_d;
   logic              restart;
   logic              valid_q;

   // Plain files always play segment zero
   wire seq_sel    = is_seq & (seq_mode == SEQ_SINGLE);
   wire seq_walk   = is_seq & (seq_mode != SEQ_SINGLE);
   wire [SEG_W-1:0] first_seg = (is_seq & (seq_mode != SEQ_FULL)) ? segidx_q : 8'h00;
   wire [IDX_W-1:0] len_m1    = (length_q == 16'h0000) ? 16'h0000 : length_q - 16'h0001;
   wire [SEG_W-1:0] nseg_m1   = (nseg_q == 8'h00) ? 8'h00 : nseg_q - 8'h01;
   wire last_sample = (idx_q == len_m1);
   wire seg_last    = ~seq_walk | (seg_q >= nseg_m1);
   wire step        = (st_q == ST_RUN) & sample_en & ((mode != MODE_GATED) | gate_act);
   wire pass_end    = step & last_sample & seg_last;
   wire [REP_W-1:0] rep_load  = (repeat_q == 16'h0000) ? 16'h0001 : repeat_q;

   always_comb begin
      st_d    = st_q;
      rep_d   = rep_q;
      pend_d  = pend_q;
      restart = 1'b0;
      case (st_q)
         ST_OFF: begin
            if (enable) begin
               restart = 1'b1;
               st_d    = (((mode == MODE_CONT) & (csub == CSUB_AUTO)) | (mode == MODE_GATED)) ? ST_RUN : ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (trig & (mode != MODE_GATED)) begin
               restart = 1'b1;
               st_d    = ST_RUN;
               rep_d   = rep_load;
               pend_d  = 1'b0;
            end
         end
         ST_RUN: begin
            case (mode)
               MODE_CONT: begin
                  restart = trig & (csub == CSUB_RT);
               end
               MODE_SINGLE: begin
                  if (trig & (spol == SPOL_RT)) begin
                     restart = 1'b1;
                  end else if (pass_end) begin
                     if (pend_q | (trig & (spol == SPOL_BUFFER))) begin
                        restart = 1'b1;
                        // A retrigger in the same cycle as a pending replay buffers the next pass
                        pend_d  = pend_q & trig & (spol == SPOL_BUFFER);
                     end else begin
                        st_d = ST_WAIT;
                     end
                  end else if (trig & (spol == SPOL_BUFFER)) begin
                     pend_d = 1'b1;
                  end
               end
               MODE_REPEAT: begin
                  if (pass_end) begin
                     if (rep_q <= 16'h0001) begin
                        st_d = ST_WAIT;
                     end else begin
                        rep_d = rep_q - 16'h0001;
                     end
                  end
               end
               default: begin
                  restart = 1'b0;
               end
            endcase
         end
         default: begin
            st_d = ST_OFF;
         end
      endcase
      // A control write or disable returns to idle so stale state cannot play
      if (!enable | wr_ctrl) begin
         st_d    = ST_OFF;
         restart = 1'b0;
         pend_d  = 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         st_q   <= ST_OFF;
         rep_q  <= '0;
         pend_q <= 1'b0;
      end else begin
         st_q   <= st_d;
         rep_q  <= rep_d;
         pend_q <= pend_d;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         idx_q   <= '0;
         seg_q   <= '0;
         valid_q <= 1'b0;
      end else begin
         // The closing sample of a pass still leaves before a replay
         valid_q <= step & (~restart | pass_end);
         if (restart) begin
            idx_q <= '0;
            seg_q <= first_seg;
         end else if (step) begin
            idx_q <= last_sample ? 16'h0000 : idx_q + 16'h0001;
            if (last_sample) begin
               seg_q <= seg_last ? first_seg : seg_q + 8'h01;
            end
         end
      end
   end

   assign sample_idx    = idx_q;
   assign sample_seg    = seg_q;
   assign sample_valid  = valid_q;
   assign other_mod_off = enable;

   // ----------------------------------------
   // Read back
   // ----------------------------------------
   wire [DATA_W-1:0] status_word = {rep_q, seg_q, 4'h0, dly_busy, pend_q, st_q == ST_WAIT, st_q == ST_RUN};
   wire [DATA_W-1:0] rd_mux =
      (reg_addr == OFS_CTRL)   ? {17'h00000, ctrl_q} :
      (reg_addr == OFS_REPEAT) ? {16'h0000, repeat_q} :
      (reg_addr == OFS_DELAY)  ? {8'h00, delay_q} :
      (reg_addr == OFS_SEGIDX) ? {24'h000000, segidx_q} :
      (reg_addr == OFS_CLKDIV) ? {16'h0000, clkdiv_q} :
      (reg_addr == OFS_STATUS) ? status_word :
      (reg_addr == OFS_LENGTH) ? {16'h0000, length_q} :
      (reg_addr == OFS_NSEG)   ? {24'h000000, nseg_q} : 32'h00000000;

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         rdata_q <= '0;
      end else begin
         rdata_q <= reg_rd ? rd_mux : 32'h00000000;
      end
   end
   assign reg_rdata = rdata_q;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   a_cont_keeps_run: assert property (
      st_q == ST_RUN && mode == MODE_CONT && pass_end && enable && !wr_ctrl |=> st_q == ST_RUN && idx_q == 16'h0000)
      else $error("continuous play stopped at pass end");
   a_single_stops: assert property (
      st_q == ST_RUN && mode == MODE_SINGLE && spol == SPOL_IGNORE && pass_end && enable && !wr_ctrl
      |=> st_q == ST_WAIT ##1 !sample_valid) else $error("single play did not stop");
   a_gate_pause: assert property (
      st_q == ST_RUN && mode == MODE_GATED && !gate_act |=> $stable(idx_q) && !sample_valid)
      else $error("gated play advanced while gate inactive");
   a_repeat_burst_end: assert property (
      st_q == ST_RUN && mode == MODE_REPEAT && pass_end && rep_q == 16'h0001 && enable && !wr_ctrl
      |=> st_q == ST_WAIT) else $error("repeat burst did not end");
   a_key_trigger: assert property (
      st_q == ST_WAIT && !src_ext && wr_exec && mode != MODE_GATED && enable |=> st_q == ST_RUN && idx_q == 16'h0000)
      else $error("key execute did not start play");
   a_rt_restart: assert property (
      st_q == ST_RUN && mode == MODE_SINGLE && spol == SPOL_RT && trig && enable && !wr_ctrl
      |=> idx_q == 16'h0000 && st_q == ST_RUN) else $error("real time retrigger did not restart");
   a_buffer_replay: assert property (
      st_q == ST_RUN && mode == MODE_SINGLE && spol == SPOL_BUFFER && pend_q && pass_end && enable && !wr_ctrl
      |=> st_q == ST_RUN && pend_q == $past(trig)) else $error("buffered retrigger lost");
   a_seg_select: assert property (
      restart && seq_sel |=> seg_q == $past(segidx_q)) else $error("selected segment not played");
endmodule : arb_playback_trigger_ctrl
`default_nettype wire

// ### test/ext_partner.sv
// Far-side model: external trigger source and sample consumer
`default_nettype none
module ext_partner (
   input  wire logic ref_clk,
   input  wire logic sample_valid,
   output logic      ext_trig_in
);
   timeunit 1ns;
   timeprecision 1ns;

   int valid_cnt = 0;

   // ----------------------------------------
   // Trigger and gate source
   // ----------------------------------------
   initial ext_trig_in = 1'b0;

   // Level changes just after an edge and holds until the next call
   task automatic drive(input logic lvl);
      @(posedge ref_clk);
      ext_trig_in <= lvl;
   endtask : drive

   // ----------------------------------------
   // Sample sink
   // ----------------------------------------
   // Never stalls: the output path has no back pressure
   always @(posedge ref_clk) begin
      if (sample_valid === 1'b1) valid_cnt <= valid_cnt + 1;
   end
endmodule : ext_partner
`default_nettype wire

// ### test/tb_top.sv
// Self-checking testbench for the playback trigger controller
`default_nettype none
module tb_top
   import playback_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic              ref_clk, rstn, reg_wr, reg_rd;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata, reg_rdata, rd_val;
   logic [SEG_W-1:0]  sample_seg, seg_a, seg_b;
   logic [IDX_W-1:0]  sample_idx;
   logic              sample_valid, other_mod_off, ext_trig_in;
   int                miscompares = 0, comparisons = 0, base_cnt, lat0, lat1;

   logic [ADDR_W-1:0] ra [8] = '{OFS_CTRL, OFS_REPEAT, OFS_DELAY, OFS_SEGIDX, OFS_CLKDIV, OFS_LENGTH, OFS_NSEG, 8'h40};
   logic [DATA_W-1:0] rv [8] = '{32'(RST_CTRL), 32'(RST_REPEAT), 32'(RST_DELAY), 32'(RST_SEGIDX),
                                 32'(RST_CLKDIV), 32'(RST_LENGTH), 32'(RST_NSEG), 32'h0};
   int                pol_lo [3] = '{8, 16, 9};
   int                pol_hi [3] = '{8, 16, 15};
   logic [DATA_W-1:0] sq_f [4] = '{32'h2000, 32'h1000, 32'h3000, 32'h5000};
   logic [DATA_W-1:0] sq_a [4] = '{32'h0, 32'h2, 32'h2, 32'h0};
   logic [DATA_W-1:0] sq_b [4] = '{32'h0, 32'h2, 32'h3, 32'h1};

   arb_playback_trigger_ctrl arb_playback_trigger_ctrl_i (
      .ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_trig_in(ext_trig_in), .sample_seg(sample_seg),
      .sample_idx(sample_idx), .sample_valid(sample_valid), .other_mod_off(other_mod_off));
   ext_partner ext_partner_i (.ref_clk(ref_clk), .sample_valid(sample_valid), .ext_trig_in(ext_trig_in));

   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic stop_test();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : stop_test

   task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : cyc

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge ref_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr    <= 1'b0;
   endtask : wr

   task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
      @(posedge ref_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd   <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd

   function automatic logic [DATA_W-1:0] ctl(input logic [1:0] m, s, p, input logic [DATA_W-1:0] f);
      return f | ({30'h0, m} << F_MODE_LO) | ({30'h0, s} << F_CSUB_LO) | ({30'h0, p} << F_SPOL_LO) | 32'h1;
   endfunction : ctl

   function automatic logic [DATA_W-1:0] inr(input int v, lo, hi);
      return {31'h0, (v >= lo && v <= hi)};
   endfunction : inr

   task automatic mark();
      base_cnt = ext_partner_i.valid_cnt;
   endtask : mark

   function automatic logic [DATA_W-1:0] got();
      return 32'(ext_partner_i.valid_cnt - base_cnt);
   endfunction : got

   // Bounded: a stuck player ends the run instead of hanging it
   task automatic lat_to_valid(output int n);
      n = 0;
      while (sample_valid !== 1'b1) begin
         @(posedge ref_clk);
         n++;
         if (n > 200) begin
            chk(32'h0, 32'h1);
            stop_test();
         end
      end
   endtask : lat_to_valid

   task automatic seg_pair(output logic [SEG_W-1:0] a, b);
      int k = 0;
      for (int t = 0; t < 200 && k < 9; t++) begin
         @(posedge ref_clk);
         if (sample_valid === 1'b1) begin
            k++;
            if (k == 1) a = sample_seg;
            if (k == 9) b = sample_seg;
         end
      end
      if (k < 9) begin
         chk(32'h0, 32'h1);
         stop_test();
      end
   endtask : seg_pair

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      rstn      = 1'b0;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_addr  = 8'h00;
      reg_wdata = 32'h0;
      cyc(10);
      rstn <= 1'b1;
      cyc(1);
      chk({31'h0, other_mod_off}, 32'h0);
      for (int i = 0; i < 8; i++) begin
         rd(ra[i], rd_val);
         chk(rd_val, rv[i]);
      end
      wr(OFS_LENGTH, 32'h8);
      wr(OFS_REPEAT, 32'h3);
      // Second key trigger lands mid-pass, once per retrigger policy
      for (int p = 0; p < 3; p++) begin
         wr(OFS_CTRL, ctl(MODE_SINGLE, CSUB_AUTO, 2'(p), 32'h0));
         mark();
         wr(OFS_EXEC, 32'h0);
         chk({31'h0, other_mod_off}, 32'h1);
         cyc(2);
         wr(OFS_EXEC, 32'h0);
         cyc(40);
         chk(inr(int'(got()), pol_lo[p], pol_hi[p]), 32'h1);
      end
      wr(OFS_CTRL, ctl(MODE_REPEAT, CSUB_AUTO, SPOL_IGNORE, 32'h0));
      mark();
      wr(OFS_EXEC, 32'h0);
      cyc(60);
      chk(got(), 32'h18);
      rd(OFS_STATUS, rd_val);
      chk(rd_val, 32'h00010002);
      for (int s = 0; s < 3; s++) begin
         wr(OFS_CTRL, ctl(MODE_CONT, 2'(s), SPOL_IGNORE, 32'h0));
         cyc(3);
         mark();
         cyc(20);
         chk(got(), s == 0 ? 32'h14 : 32'h0);
         wr(OFS_EXEC, 32'h0);
         cyc(3);
         mark();
         cyc(40);
         chk(got(), 32'h28);
      end
      wr(OFS_CLKDIV, 32'h3);
      wr(OFS_CTRL, ctl(MODE_CONT, CSUB_AUTO, SPOL_IGNORE, 32'h0));
      cyc(8);
      mark();
      cyc(40);
      chk(got(), 32'hA);
      wr(OFS_CLKDIV, 32'h0);
      for (int s = 0; s < 2; s++) begin
         ext_partner_i.drive(1'(s));
         wr(OFS_CTRL, ctl(MODE_SINGLE, CSUB_AUTO, SPOL_IGNORE, 32'h2 | (32'(s) << F_SLOPE_FALL)));
         cyc(5);
         mark();
         ext_partner_i.drive(1'(s == 0));
         cyc(30);
         chk(got(), 32'h8);
         mark();
         ext_partner_i.drive(1'(s));
         cyc(30);
         chk(got(), 32'h0);
      end
      // Half-rate samples tell the sample unit from the time unit
      wr(OFS_CLKDIV, 32'h1);
      for (int u = 0; u < 3; u++) begin
         ext_partner_i.drive(1'b0);
         wr(OFS_DELAY, u == 2 ? 32'h3E8 : 32'hA);
         wr(OFS_CTRL, ctl(MODE_SINGLE, CSUB_AUTO, SPOL_IGNORE, u == 0 ? 32'h2 : (u == 1 ? 32'h402 : 32'hC02)));
         cyc(5);
         ext_partner_i.drive(1'b1);
         lat_to_valid(lat1);
         chk(32'(sample_idx), 32'h1);
         if (u == 0) lat0 = lat1;
         if (u == 0) chk(inr(lat0, 1, 6), 32'h1);
         else chk(inr(lat1 - lat0, u == 1 ? 19 : 9, u == 1 ? 22 : 12), 32'h1);
         cyc(30);
      end
      wr(OFS_CLKDIV, 32'h0);
      for (int g = 0; g < 2; g++) begin
         ext_partner_i.drive(1'(g == 0));
         wr(OFS_CTRL, ctl(MODE_GATED, CSUB_AUTO, SPOL_IGNORE, 32'(g) << F_GATE_HIGH));
         cyc(5);
         mark();
         cyc(20);
         chk(got(), 32'h0);
         ext_partner_i.drive(1'(g == 1));
         cyc(5);
         mark();
         cyc(20);
         chk(got(), 32'h14);
      end
      wr(OFS_NSEG, 32'h4);
      wr(OFS_SEGIDX, 32'h2);
      for (int q = 0; q < 4; q++) begin
         wr(OFS_CTRL, 32'h0);
         cyc(3);
         wr(OFS_CTRL, ctl(MODE_CONT, CSUB_AUTO, SPOL_IGNORE, sq_f[q]));
         seg_pair(seg_a, seg_b);
         chk(32'(seg_a), sq_a[q]);
         chk(32'(seg_b), sq_b[q]);
      end
      stop_test();
   end

   // Watchdog far beyond the longest expected run
   initial begin
      #5_000_000;
      miscompares++;
      stop_test();
   end
endmodule : tb_top
`default_nettype wire
